// >>> smbe_map.svh
// offsets, field positions, reset values and sizes of the move and branch engine
`ifndef SMBE_MAP_SVH
`define SMBE_MAP_SVH
`define SMBE_REG_CTRL     8'h00
`define SMBE_REG_STATUS   8'h04
`define SMBE_REG_PC       8'h08
`define SMBE_REG_DSA      8'h0c
`define SMBE_REG_TEMP     8'h10
`define SMBE_REG_FBYTE    8'h14
`define SMBE_REG_SCRATCH  8'h18
`define SMBE_CTRL_START   0
`define SMBE_CTRL_TARGET  1
`define SMBE_FBYTE_CARRY  8
`define SMBE_ST_BUSY      0
`define SMBE_ST_MISMATCH  1
`define SMBE_ST_BADOP     2
`define SMBE_ST_ODD       3
`define SMBE_I_TYPE_HI    31
`define SMBE_I_TYPE_LO    30
`define SMBE_I_IND        29
`define SMBE_I_TBL        28
`define SMBE_I_CHAIN      27
`define SMBE_I_OP_HI      29
`define SMBE_I_OP_LO      27
`define SMBE_I_PH_HI      26
`define SMBE_I_PH_LO      24
`define SMBE_I_REL        23
`define SMBE_I_CARRY      21
`define SMBE_I_TF         19
`define SMBE_I_CMPD       18
`define SMBE_I_CMPP       17
`define SMBE_I_WAIT       16
`define SMBE_T_MOVE       2'h0
`define SMBE_T_TC         2'h1
`define SMBE_T_MEM        2'h3
`define SMBE_OP_JUMP      3'h0
`define SMBE_OP_CALL      3'h1
`define SMBE_OP_RET       3'h2
`define SMBE_OP_NOP       3'h3
`define SMBE_FIFO_DEPTH   4'h8
`define SMBE_RST_WORD     32'h0000_0000
`endif

// >>> smbe_pkg.sv
// types shared by the move and branch engine
package smbe_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_FETCH, S_DECODE, S_PTR, S_PHASE, S_MOVE, S_TCW, S_MMRD, S_MMWR
  } smbe_state_e;
  typedef struct packed {
    logic        req;
    logic        we;
    logic        word;
    logic [31:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } smbe_mem_s;
endpackage

// >>> smbe_engine.sv
// script move and branch engine with apb registers and a host memory master port
//
// Behaviour
// RULE1: chained wide move holds odd byte for next
// RULE2: direct move takes count and address directly
// RULE3: indirect move fetches pointer to buffer address
// RULE4: table form adds signed offset to base
// RULE5: target drives phase, initiator tests phase
// RULE6: memory move reads to fifo then writes
// RULE7: memory move leaves return and base registers
// RULE8: memory move: 24-bit count, direct addresses, autonomous
// RULE9: software keeps source and destination lanes equal
// RULE10: memory move may address own registers
// RULE11: taken jump loads target, saves nothing
// RULE12: taken call saves return address, one level
// RULE13: wait bit waits for valid phase first
// RULE14: true/false bit selects branch polarity
// RULE15: phase compare uses held phase bits
// RULE16: data compare with first byte, mask excludes
// RULE17: carry test uses carry bit alone
// RULE18: target role can test atn
// RULE19: phase and data combine: and / nand
// RULE20: relative branch adds signed displacement to pc
// RULE21: software ends chained list with plain move
// RULE22: initiator phase mismatch raises external interrupt
// RULE23: count reaching zero fetches next instruction
// RULE24: taken return branches to saved address
// RULE25: nop form never branches
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "smbe_map.svh"
module smbe_engine
  import smbe_pkg::*;
#(
  parameter logic [31:0] REG_WIN_BASE = 32'hffff_ff00
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output smbe_mem_s        mem_o,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        scsi_req,
  input  wire logic [2:0]  scsi_phase_in,
  input  wire logic        scsi_atn_in,
  output logic      [2:0]  scsi_phase_out,
  output logic             scsi_phase_oe_n,
  output logic      [15:0] scsi_data_out,
  output logic             scsi_data_strobe,
  output logic             mismatch_irq
);

  smbe_state_e st;
  logic [4:0]  sync1;
  logic [4:0]  sync2;
  logic        req_s;
  logic        atn_s;
  logic [2:0]  phase_s;
  logic        target;
  logic        busy;
  logic        bad_op;
  logic [31:0] pc;
  logic [31:0] data_structure_base;
  logic [31:0] temp;
  logic [7:0]  first_byte;
  logic        carry;
  logic [31:0] scratch;
  logic [31:0] iw [3];
  logic [1:0]  fidx;
  logic [23:0] cnt;
  logic [31:0] addr;
  logic [31:0] dst;
  logic        chained;
  logic        have_odd;
  logic [7:0]  odd_byte;
  logic [7:0]  fifo [8];
  logic [3:0]  fill;
  logic [3:0]  drain;
  logic        apb_wr;
  logic        ack;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic [1:0]  ilen;
  logic [1:0]  itype;
  logic [2:0]  iop;
  logic        p_ok;
  logic        d_ok;
  logic        cond;
  logic        take;
  logic [31:0] tgt;
  logic [7:0]  lane_byte;
  logic        src_win;
  logic        dst_win;
  logic [7:0]  src_byte;
  logic [31:0] src_word;

  // pin inputs pass two flip-flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else begin
      sync1 <= {scsi_req, scsi_atn_in, scsi_phase_in};
      sync2 <= sync1;
    end
  end
  assign req_s   = sync2[4];
  assign atn_s   = sync2[3];
  assign phase_s = sync2[2:0];

  assign apb_wr = psel && penable && pwrite && pready;
  assign ack    = mem_o.req && mem_ack;
  assign itype  = iw[0][`SMBE_I_TYPE_HI:`SMBE_I_TYPE_LO];
  assign iop    = iw[0][`SMBE_I_OP_HI:`SMBE_I_OP_LO];
  assign ilen   = (itype == `SMBE_T_MEM) ? 2'h2 : 2'h1;
  assign lane_byte = mem_rdata[{addr[1:0], 3'h0} +: 8];
  assign src_win   = addr[31:5] == REG_WIN_BASE[31:5];
  assign dst_win   = dst[31:5] == REG_WIN_BASE[31:5];

  function automatic logic [31:0] reg_word(input logic [7:0] off);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (off)
      `SMBE_REG_CTRL:    v = {30'h0, target, 1'b0};
      `SMBE_REG_STATUS:  v = {28'h0, have_odd, bad_op, mismatch_irq, busy};
      `SMBE_REG_PC:      v = pc;
      `SMBE_REG_DSA:     v = data_structure_base;
      `SMBE_REG_TEMP:    v = temp;
      `SMBE_REG_FBYTE:   v = {23'h0, carry, first_byte};
      `SMBE_REG_SCRATCH: v = scratch;
      default:           v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // register window byte read for memory moves
  always_comb begin
    src_word = reg_word({3'h0, addr[4:2], 2'h0});
    src_byte = src_word[{addr[1:0], 3'h0} +: 8]; //RULE10
  end

  // branch condition
  always_comb begin
    p_ok = 1'b1;
    d_ok = 1'b1;
    if (iw[0][`SMBE_I_CMPP]) begin
      p_ok = target ? atn_s : (phase_s == iw[0][`SMBE_I_PH_HI:`SMBE_I_PH_LO]); //RULE15 RULE18
    end
    if (iw[0][`SMBE_I_CMPD]) begin
      d_ok = ((first_byte ^ iw[0][7:0]) & ~iw[0][15:8]) == 8'h00; //RULE16
    end
    cond = iw[0][`SMBE_I_CARRY] ? carry : (p_ok && d_ok); //RULE17 RULE19
    take = iw[0][`SMBE_I_TF] ? cond : !cond; //RULE14
    if (iw[0][`SMBE_I_REL]) begin
      tgt = pc + {{8{iw[1][23]}}, iw[1][23:0]}; //RULE20
    end else begin
      tgt = iw[1];
    end
  end

  // apb read mux
  always_comb begin
    rd_val = reg_word(paddr);
    rd_ok  = (paddr <= `SMBE_REG_SCRATCH) && (paddr[1:0] == 2'h0);
  end

  // apb response: one wait-free access cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= `SMBE_RST_WORD;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable && !pready;
      prdata  <= (psel && !penable && !pwrite && rd_ok) ? rd_val : 32'h0000_0000;
      pslverr <= psel && !penable && !rd_ok;
    end
  end

  // engine and software-visible state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st               <= S_IDLE;
      target           <= 1'b0;
      busy             <= 1'b0;
      bad_op           <= 1'b0;
      mismatch_irq     <= 1'b0;
      pc               <= `SMBE_RST_WORD;
      data_structure_base              <= `SMBE_RST_WORD;
      temp             <= `SMBE_RST_WORD;
      first_byte       <= 8'h00;
      carry            <= 1'b0;
      scratch          <= `SMBE_RST_WORD;
      iw[0]            <= `SMBE_RST_WORD;
      iw[1]            <= `SMBE_RST_WORD;
      iw[2]            <= `SMBE_RST_WORD;
      fidx             <= 2'h0;
      cnt              <= 24'h00_0000;
      addr             <= `SMBE_RST_WORD;
      dst              <= `SMBE_RST_WORD;
      chained          <= 1'b0;
      have_odd         <= 1'b0;
      odd_byte         <= 8'h00;
      fill             <= 4'h0;
      drain            <= 4'h0;
      mem_o            <= '0;
      scsi_phase_out   <= 3'h0;
      scsi_phase_oe_n  <= 1'b1;
      scsi_data_out    <= 16'h0000;
      scsi_data_strobe <= 1'b0;
    end else begin
      scsi_data_strobe <= 1'b0;
      if (apb_wr) begin
        case (paddr)
          `SMBE_REG_CTRL: begin
            target <= pwdata[`SMBE_CTRL_TARGET];
            if (pwdata[`SMBE_CTRL_START] && !busy) begin
              busy         <= 1'b1;
              bad_op       <= 1'b0;
              mismatch_irq <= 1'b0;
              fidx         <= 2'h0;
              st           <= S_FETCH;
            end
          end
          `SMBE_REG_PC:      pc <= pwdata;
          `SMBE_REG_DSA:     data_structure_base <= pwdata;
          `SMBE_REG_FBYTE: begin
            first_byte <= pwdata[7:0];
            carry      <= pwdata[`SMBE_FBYTE_CARRY];
          end
          `SMBE_REG_SCRATCH: scratch <= pwdata;
          default: begin
          end
        endcase
      end
      case (st)
        S_IDLE: begin
        end
        S_FETCH: begin
          if (ack) begin
            mem_o.req <= 1'b0;
            iw[fidx]  <= mem_rdata;
            fidx      <= fidx + 2'h1;
            if (fidx != 2'h0 && fidx == ((iw[0][31:30] == `SMBE_T_MEM) ? 2'h2 : 2'h1)) begin
              st <= S_DECODE;
            end
          end else if (!mem_o.req) begin
            mem_o <= '{req: 1'b1, we: 1'b0, word: 1'b1, addr: pc + {28'h0, fidx, 2'h0},
                       be: 4'hf, wdata: 32'h0000_0000};
          end
        end
        S_DECODE: begin
          pc   <= pc + {28'h0, ilen, 2'h0} + 32'h0000_0004;
          fidx <= 2'h0;
          case (itype)
            `SMBE_T_MOVE: begin
              cnt     <= iw[0][23:0]; //RULE2
              chained <= iw[0][`SMBE_I_CHAIN];
              st      <= S_PHASE;
              if (iw[0][`SMBE_I_IND]) begin
                addr <= iw[1];
                st   <= S_PTR;
              end else if (iw[0][`SMBE_I_TBL]) begin
                addr <= data_structure_base + {{8{iw[1][23]}}, iw[1][23:0]}; //RULE4
              end else begin
                addr <= iw[1]; //RULE2
              end
            end
            `SMBE_T_TC: st <= S_TCW;
            `SMBE_T_MEM: begin
              cnt  <= iw[0][23:0]; //RULE8
              addr <= iw[1]; //RULE8
              dst  <= iw[2];
              fill <= 4'h0;
              st   <= S_MMRD;
            end
            default: begin
              bad_op <= 1'b1;
              busy   <= 1'b0;
              st     <= S_IDLE;
            end
          endcase
        end
        S_PTR: begin
          if (ack) begin
            mem_o.req <= 1'b0;
            addr      <= mem_rdata; //RULE3
            st        <= S_PHASE;
          end else if (!mem_o.req) begin
            mem_o <= '{req: 1'b1, we: 1'b0, word: 1'b1, addr: addr,
                       be: 4'hf, wdata: 32'h0000_0000};
          end
        end
        S_PHASE: begin
          if (target) begin
            scsi_phase_out  <= iw[0][`SMBE_I_PH_HI:`SMBE_I_PH_LO]; //RULE5
            scsi_phase_oe_n <= 1'b0;
            st              <= S_MOVE;
          end else if (req_s) begin
            scsi_phase_oe_n <= 1'b1;
            if (phase_s == iw[0][`SMBE_I_PH_HI:`SMBE_I_PH_LO]) begin //RULE5
              st <= S_MOVE;
            end else begin
              mismatch_irq <= 1'b1; //RULE22
              busy         <= 1'b0;
              st           <= S_IDLE;
            end
          end
        end
        S_MOVE: begin
          if (cnt == 24'h00_0000) begin
            if (have_odd && !chained) begin
              scsi_data_out    <= {8'h00, odd_byte};
              scsi_data_strobe <= 1'b1;
              have_odd         <= 1'b0;
            end
            st <= S_FETCH; //RULE23 RULE1
          end else if (ack) begin
            mem_o.req <= 1'b0;
            addr      <= addr + 32'h0000_0001;
            cnt       <= cnt - 24'h00_0001;
            if (have_odd) begin
              scsi_data_out    <= {lane_byte, odd_byte}; //RULE1
              scsi_data_strobe <= 1'b1;
              have_odd         <= 1'b0;
            end else begin
              odd_byte <= lane_byte; //RULE1
              have_odd <= 1'b1;
            end
          end else if (!mem_o.req) begin
            mem_o <= '{req: 1'b1, we: 1'b0, word: 1'b0, addr: addr,
                       be: 4'h1 << addr[1:0], wdata: 32'h0000_0000};
          end
        end
        S_TCW: begin
          if (!iw[0][`SMBE_I_WAIT] || req_s) begin //RULE13
            st <= S_FETCH;
            if (take) begin
              case (iop)
                `SMBE_OP_JUMP: pc <= tgt; //RULE11
                `SMBE_OP_CALL: begin
                  temp <= pc; //RULE12
                  pc   <= tgt;
                end
                `SMBE_OP_RET: pc <= temp; //RULE24
                `SMBE_OP_NOP: begin //RULE25
                end
                default: begin
                  bad_op <= 1'b1;
                  busy   <= 1'b0;
                  st     <= S_IDLE;
                end
              endcase
            end
          end
        end
        S_MMRD: begin
          if (cnt == 24'h00_0000 || fill == `SMBE_FIFO_DEPTH) begin
            drain <= 4'h0;
            st    <= (fill == 4'h0) ? S_FETCH : S_MMWR; //RULE23
          end else if (src_win || ack) begin
            mem_o.req     <= 1'b0;
            fifo[fill[2:0]] <= src_win ? src_byte : lane_byte; //RULE6 RULE10
            fill          <= fill + 4'h1;
            addr          <= addr + 32'h0000_0001;
            cnt           <= cnt - 24'h00_0001;
          end else if (!mem_o.req) begin
            mem_o <= '{req: 1'b1, we: 1'b0, word: 1'b0, addr: addr,
                       be: 4'h1 << addr[1:0], wdata: 32'h0000_0000};
          end
        end
        S_MMWR: begin
          if (drain == fill) begin
            fill <= 4'h0;
            st   <= S_MMRD;
          end else if (dst_win || ack) begin
            mem_o.req <= 1'b0;
            drain     <= drain + 4'h1;
            dst       <= dst + 32'h0000_0001;
            if (dst_win) begin
              // only first byte and scratch accept writes; base and return stay intact
              if ({3'h0, dst[4:2], 2'h0} == `SMBE_REG_FBYTE && dst[1:0] == 2'h0) begin //RULE7
                first_byte <= fifo[drain[2:0]];
              end
              if ({3'h0, dst[4:2], 2'h0} == `SMBE_REG_SCRATCH) begin //RULE10
                scratch[{dst[1:0], 3'h0} +: 8] <= fifo[drain[2:0]];
              end
            end
          end else if (!mem_o.req) begin
            mem_o <= '{req: 1'b1, we: 1'b1, word: 1'b0, addr: dst, be: 4'h1 << dst[1:0],
                       wdata: {4{fifo[drain[2:0]]}}}; //RULE6
          end
        end
        default: st <= S_IDLE;
      endcase
    end
  end

endmodule

// >>> smbe_chk.sv
// port checker for the move and branch engine
`timescale 1ns/1ps
module smbe_chk
  import smbe_pkg::*;
(
  input wire logic      pclk,
  input wire logic      presetn,
  input wire logic      psel,
  input wire logic      penable,
  input wire logic      pready,
  input wire logic      pslverr,
  input wire smbe_mem_s mem_o,
  input wire logic      mem_ack,
  input wire logic      scsi_phase_oe_n,
  input wire logic      scsi_data_strobe,
  input wire logic      mismatch_irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_fetch_word;
    mem_o.req && mem_o.word |-> mem_o.be == 4'hf && mem_o.addr[1:0] == 2'h0 && !mem_o.we;
  endproperty
  a_fetch_word: assert property (p_fetch_word)
    else $error("word fetch not aligned read");
  property p_byte_lane;
    mem_o.req && !mem_o.word |-> mem_o.be == (4'h1 << mem_o.addr[1:0]);
  endproperty
  a_byte_lane: assert property (p_byte_lane)
    else $error("byte enable off its lane");
  property p_wr_repl;
    mem_o.req && mem_o.we |-> !mem_o.word && mem_o.wdata == {4{mem_o.wdata[7:0]}};
  endproperty
  a_wr_repl: assert property (p_wr_repl)
    else $error("memory write not a replicated byte");
  property p_req_hold;
    mem_o.req && !mem_ack |=> mem_o.req && $stable(mem_o);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("memory request changed before answer");
  property p_req_drop;
    mem_o.req && mem_ack |=> !mem_o.req;
  endproperty
  a_req_drop: assert property (p_req_drop)
    else $error("memory request held after answer");
  property p_strobe_gap;
    scsi_data_strobe |=> !scsi_data_strobe;
  endproperty
  a_strobe_gap: assert property (p_strobe_gap)
    else $error("data strobes back to back");
  property p_irq_quiet;
    mismatch_irq |-> !scsi_data_strobe;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("data sent during phase mismatch");
  property p_irq_oe;
    mismatch_irq |-> scsi_phase_oe_n;
  endproperty
  a_irq_oe: assert property (p_irq_oe)
    else $error("phase driven during initiator mismatch");
  property p_apb_answer;
    psel && !penable |=> pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("no ready after setup");
  property p_apb_single;
    pready |=> !pready;
  endproperty
  a_apb_single: assert property (p_apb_single)
    else $error("ready longer than one cycle");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("error without ready");
endmodule

// >>> smbe_host_mem.sv
// host memory model answering the engine's memory requests
`timescale 1ns/1ps
module smbe_host_mem
  import smbe_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire smbe_mem_s  mem_o,
  output logic            mem_ack,
  output logic     [31:0] mem_rdata
);
  logic [7:0] m [0:1023];
  logic [1:0] cnt;
  logic [1:0] lat;
  logic [9:0] a;
  initial for (int i = 0; i < 1024; i++) m[i] = i[7:0] ^ 8'ha5;
  task put(input logic [9:0] ad, input logic [31:0] w);
    {m[ad+3], m[ad+2], m[ad+1], m[ad]} = w;
  endtask
  assign a = {mem_o.addr[9:2], 2'b00};
  // answer latency alternates between prompt and slow
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      cnt <= 2'h0;
      lat <= 2'h0;
      mem_rdata <= 32'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_o.req && !mem_ack) begin
        if (cnt == lat) begin
          mem_ack <= 1'b1;
          cnt <= 2'h0;
          lat <= lat ^ 2'h2;
          mem_rdata <= {m[a+3], m[a+2], m[a+1], m[a]};
          if (mem_o.we) for (int j = 0; j < 4; j++) if (mem_o.be[j]) m[a+j] <= mem_o.wdata[8*j+:8];
        end else cnt <= cnt + 2'h1;
      end
    end
  end
endmodule

// >>> script_move_branch_engine_bench.sv
// self-checking bench for the script move and branch engine
`timescale 1ns/1ps
`include "smbe_map.svh"
module script_move_branch_engine_bench;
  import smbe_pkg::*;
  logic        pclk;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic        scsi_req = 1'b1;
  logic [2:0]  scsi_phase_in = 3'h0;
  logic        scsi_atn_in = 1'b0;
  logic [31:0] prdata, mem_rdata, last_fetch, rd_val;
  logic        pready, pslverr, mem_ack, rd_err, scsi_phase_oe_n, scsi_data_strobe, mismatch_irq;
  logic [2:0]  scsi_phase_out;
  logic [15:0] scsi_data_out;
  smbe_mem_s   mem_o;
  logic [15:0] strobes[$];
  int          n_errors = 0;
  int          tests_run = 0;

  smbe_engine uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mem_o, .mem_ack, .mem_rdata, .scsi_req, .scsi_phase_in, .scsi_atn_in,
    .scsi_phase_out, .scsi_phase_oe_n, .scsi_data_out, .scsi_data_strobe, .mismatch_irq);
  smbe_host_mem u_mem (.pclk, .presetn, .mem_o, .mem_ack, .mem_rdata);

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (mem_o.req && mem_ack && mem_o.word) last_fetch <= mem_o.addr;
    if (scsi_data_strobe) strobes.push_back(scsi_data_out);
  end

  function automatic logic [7:0] f(input logic [31:0] a);
    return a[7:0] ^ 8'ha5;
  endfunction
  task summarize;
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      n_errors++;
      summarize;
    end
    rd_val = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task ld(input logic [9:0] a, input logic [31:0] w0, input logic [31:0] w1);
    u_mem.put(a, w0);
    u_mem.put(a + 10'h4, w1);
  endtask
  task run(input logic [31:0] pc, input logic [31:0] ctrl);
    strobes.delete();
    apb(1'b1, `SMBE_REG_PC, pc);
    apb(1'b1, `SMBE_REG_CTRL, ctrl);
    settle;
  endtask
  task settle;
    int n;
    for (n = 0; n < 200; n++) begin
      apb(1'b0, `SMBE_REG_STATUS, 32'h0);
      if (rd_val[0] === 1'b0) break;
    end
    if (n == 200) begin
      n_errors++;
      summarize;
    end
  endtask
  task rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd_val, exp);
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 'h18; a += 4) begin
      rd("reset value", a[7:0], 32'h0);
      chk("slverr", {31'h0, rd_err}, 32'h0);
    end
    rd("unmapped data", 8'h1c, 32'h0);
    chk("unmapped err", {31'h0, rd_err}, 32'h1);
    // call, two memory moves, return, masked relative jump, halt
    ld(10'h000, 32'h4808_0000, 32'h40);
    ld(10'h040, 32'hc000_0004, 32'h100);
    u_mem.put(10'h048, 32'h200);
    ld(10'h04c, 32'hc000_0004, 32'h100);
    u_mem.put(10'h054, 32'hffff_ff18);
    ld(10'h058, 32'h5008_0000, 32'h0);
    ld(10'h008, 32'h408c_7f80, 32'h50);
    ld(10'h060, 32'h8000_0000, 32'h0);
    ld(10'h300, 32'h8000_0000, 32'h0);
    apb(1'b1, `SMBE_REG_FBYTE, 32'h85);
    apb(1'b1, `SMBE_REG_DSA, 32'h1234_5678);
    run(32'h0, 32'h1);
    chk("branch path", {last_fetch[31:3], 3'h0}, 32'h60);
    rd("return reg", `SMBE_REG_TEMP, 32'h8);
    rd("base reg", `SMBE_REG_DSA, 32'h1234_5678);
    chk("copied word", {u_mem.m[515], u_mem.m[514], u_mem.m[513], u_mem.m[512]},
      {f(259), f(258), f(257), f(256)});
    rd("scratch copy", `SMBE_REG_SCRATCH, {f(259), f(258), f(257), f(256)});
    rd("status", `SMBE_REG_STATUS, 32'h4);
    // no-op then jump-if-not-carry with carry set: both fall through
    ld(10'h080, 32'h5800_0000, 32'h300);
    ld(10'h088, 32'h4020_0000, 32'h300);
    ld(10'h090, 32'h8000_0000, 32'h0);
    apb(1'b1, `SMBE_REG_FBYTE, 32'h100);
    run(32'h80, 32'h1);
    chk("fall through", {last_fetch[31:3], 3'h0}, 32'h90);
    // chained direct, indirect, table form with negative offset
    ld(10'h0c0, 32'h0800_0003, 32'h100);
    ld(10'h0c8, 32'h2000_0001, 32'h180);
    u_mem.put(10'h180, 32'h110);
    ld(10'h0d0, 32'h1000_0002, 32'h00ff_fffc);
    ld(10'h0d8, 32'h8000_0000, 32'h0);
    apb(1'b1, `SMBE_REG_DSA, 32'h104);
    run(32'hc0, 32'h1);
    chk("word count", 32'(strobes.size()), 32'h3);
    chk("first word", {16'h0, strobes[0]}, {16'h0, f(257), f(256)});
    chk("paired odd", {16'h0, strobes[1]}, {16'h0, f(272), f(258)});
    chk("table word", {16'h0, strobes[2]}, {16'h0, f(257), f(256)});
    rd("status", `SMBE_REG_STATUS, 32'h4);
    // move whose phase differs from the bus
    ld(10'h0e0, 32'h0100_0002, 32'h100);
    run(32'he0, 32'h1);
    chk("mismatch pin", {31'h0, mismatch_irq}, 32'h1);
    chk("no data", 32'(strobes.size()), 32'h0);
    rd("status", `SMBE_REG_STATUS, 32'h2);
    // target role: move drives phase, atn test branches
    ld(10'h0f0, 32'h0500_0002, 32'h100);
    ld(10'h0f8, 32'h400a_0000, 32'h300);
    scsi_atn_in <= 1'b1;
    run(32'hf0, 32'h3);
    chk("phase out", {29'h0, scsi_phase_out}, 32'h5);
    chk("phase enable", {31'h0, scsi_phase_oe_n}, 32'h0);
    chk("atn branch", {last_fetch[31:3], 3'h0}, 32'h300);
    chk("irq cleared", {31'h0, mismatch_irq}, 32'h0);
    // wait bit holds a phase-and-data jump until the bus shows a valid phase
    ld(10'h140, 32'h400f_0000, 32'h310);
    ld(10'h310, 32'h8000_0000, 32'h0);
    scsi_req <= 1'b0;
    apb(1'b1, `SMBE_REG_PC, 32'h140);
    apb(1'b1, `SMBE_REG_CTRL, 32'h1);
    repeat (40) @(posedge pclk);
    rd("held by wait", `SMBE_REG_STATUS, 32'h1);
    scsi_req <= 1'b1;
    settle;
    chk("phase and data", {last_fetch[31:3], 3'h0}, 32'h310);
    summarize;
  end
endmodule

bind smbe_engine smbe_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .mem_o,
  .mem_ack, .scsi_phase_oe_n, .scsi_data_strobe, .mismatch_irq);
